// File: core/flow_ctrl_map.svh
// register offsets, field positions, reset values and codes
// assumes a word-addressed register bus; included by the flow control module
`ifndef FLOW_CTRL_MAP_SVH
`define FLOW_CTRL_MAP_SVH

// ==========================================
// register word offsets
`define OFS_FEATURE 4'h0
`define OFS_RESUME1 4'h1
`define OFS_RESUME2 4'h2
`define OFS_PAUSE1 4'h3
`define OFS_PAUSE2 4'h4
`define OFS_IRQ_EN 4'h5
`define OFS_IRQ_STAT 4'h6
`define OFS_FIFO_CTL 4'h7
`define OFS_MODEM_CTL 4'h8
`define OFS_MODEM_STAT 4'h9
`define OFS_DIV_LOW 4'hA
`define OFS_DIV_HIGH 4'hB
`define OFS_DIV_FRAC 4'hC
`define OFS_FLOW_STAT 4'hD

// ==========================================
// field positions and masks
`define FEAT_ENH_BIT 4
`define FEAT_SPECIAL_BIT 5
`define FEAT_ARTS_BIT 6
`define FEAT_ACTS_BIT 7
`define IER_ENH_MASK 8'hF0
`define FCR_ENH_MASK 8'h30
`define MCR_ENH_MASK 8'hE0
`define ISR_SPECIAL_BIT 4
`define ISR_XOFF_BIT 5
`define IER_SPECIAL_BIT 5
`define MCR_RTS_BIT 1

// ==========================================
// selection codes
`define SEL_NONE 2'h0
`define SEL_PAIR2 2'h1
`define SEL_PAIR1 2'h2
`define SEL_BOTH 2'h3

// ==========================================
// reset values
`define RST_BYTE 8'h00
`define RST_DIV_LOW 8'h01
`define RST_DIV_HIGH 8'h00

`endif

// File: core/flow_ctrl_pkg.sv
// types shared by the flow control block
// assumes the map header for field widths
package flow_ctrl_pkg;

    typedef enum logic [1:0] {
        FC_IDLE = 2'b01,
        FC_REMOTE_PAUSED = 2'b10
    } fc_state_type;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
        logic [7:0] irq_en;
        logic special_flag;
        logic xoff_flag;
        logic [7:0] fifo_ctl;
        logic [7:0] modem_ctl;
        logic [7:0] modem_stat;
        logic [3:0] modem_prev;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic [7:0] div_frac;
        logic ack;
        logic [31:0] rdata;
        logic seq_on;
        logic seq_off;
        logic tx_paused;
        fc_state_type fc_state;
        logic [1:0] fc_left;
        logic fc_off;
        logic ser_valid;
        logic [7:0] ser_data;
        logic fifo_valid;
        logic [7:0] fifo_data;
        logic rts_n;
    } regs_type;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] stable;
    } sync_type;

endpackage

// File: core/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin inputs and one clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // pins in, filtered levels out
    input wire logic [7:0] PIN,
    output logic [7:0] LEVEL
);
    flow_ctrl_pkg::sync_type st_r;
    flow_ctrl_pkg::sync_type st_nxt;

    // ==========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = PIN;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 8; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.stable[i] = st_r.s3[i];
            end
        end
        // in reset, levels follow the chain so they are known at release
        if (!RST_N) begin
            st_nxt.stable = st_r.s3;
        end
    end

    always_ff @(posedge CLOCK) begin
        st_r <= st_nxt;
    end

    assign LEVEL = st_r.stable;
endmodule
`default_nettype wire

// File: core/uart_flow_ctrl.sv
// enhanced feature and software flow control for one channel
// assumes receiver, transmit serialiser and FIFOs on the same clock
`timescale 1ns/10ps
`include "flow_ctrl_map.svh"
`default_nettype none
module uart_flow_ctrl (
    // clock and resets
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic POR_N,
    // avalon-mm slave
    input wire logic [3:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // received characters in, to receive fifo out
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic FIFO_VALID,
    output logic [7:0] FIFO_DATA,
    // receive fifo level flags
    input wire logic RX_AT_TRIGGER,
    input wire logic RX_BELOW_LOWER,
    // transmit characters in, to serialiser out
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    output logic TX_READY,
    output logic SER_VALID,
    output logic [7:0] SER_DATA,
    input wire logic SER_READY,
    // serial line
    input wire logic SER_BIT,
    output logic LOGIC_LEVEL_TX_OUT,
    output logic LINE_TX_OUTPUTS,
    // pins
    input wire logic [3:0] MODEM_IN_N,
    input wire logic BUS_MODE_68,
    output logic INT_OUT,
    output logic INT_OE
);
    flow_ctrl_pkg::regs_type r_r;
    flow_ctrl_pkg::regs_type r_nxt;
    logic [7:0] pin_level;
    logic [1:0] rsel;
    logic [1:0] tsel;
    logic enh;
    logic acc;
    logic wr;
    logic [7:0] wd;
    logic either_pair;
    logic seq_mode;
    logic on_hit;
    logic off_hit;
    logic special_hit;
    logic drop_char;
    logic [7:0] fc_char;
    logic irq;
    logic [3:0] modem_n;

    // ==========================================
    // pin synchronisers
    pin_sync u_sync (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .PIN({3'h7, BUS_MODE_68, MODEM_IN_N}),
        .LEVEL(pin_level)
    );
    assign modem_n = pin_level[3:0];

    // ==========================================
    // decode helpers
    assign tsel = r_r.feature[3:2];
    assign rsel = r_r.feature[1:0];
    assign enh = r_r.feature[`FEAT_ENH_BIT];
    assign acc = (READ | WRITE) & r_r.ack;
    assign wr = WRITE & r_r.ack & BYTEENABLE[0];
    assign wd = WRITEDATA[7:0];

    assign either_pair = (rsel == `SEL_BOTH) &&
        ((tsel == `SEL_PAIR1) || (tsel == `SEL_PAIR2));
    assign seq_mode = (rsel == `SEL_BOTH) && !either_pair;

    always_comb begin
        on_hit = 1'b0;
        off_hit = 1'b0;
        case (rsel)
            `SEL_PAIR1: begin
                on_hit = RX_DATA == r_r.resume1;
                off_hit = RX_DATA == r_r.pause1;
            end
            `SEL_PAIR2: begin
                on_hit = RX_DATA == r_r.resume2;
                off_hit = RX_DATA == r_r.pause2;
            end
            `SEL_BOTH: begin
                if (seq_mode) begin
                    on_hit = r_r.seq_on && (RX_DATA == r_r.resume2);
                    off_hit = r_r.seq_off && (RX_DATA == r_r.pause2);
                end else begin
                    on_hit = (RX_DATA == r_r.resume1) ||
                        (RX_DATA == r_r.resume2);
                    off_hit = (RX_DATA == r_r.pause1) ||
                        (RX_DATA == r_r.pause2);
                end
            end
            default: begin
                on_hit = 1'b0;
                off_hit = 1'b0;
            end
        endcase
    end

    assign special_hit = r_r.feature[`FEAT_SPECIAL_BIT] &&
        (RX_DATA == r_r.pause2);

    // pair one: a flow match that is also the special char keeps its char
    // pair two: pause two never stored
    assign drop_char = (on_hit || off_hit) &&
        !(special_hit && (rsel == `SEL_PAIR1));

    always_comb begin
        if (r_r.fc_left == 2'd2 || tsel == `SEL_PAIR1) begin
            fc_char = r_r.fc_off ? r_r.pause1 : r_r.resume1;
        end else begin
            fc_char = r_r.fc_off ? r_r.pause2 : r_r.resume2;
        end
    end

    // no CTS pin: line always clear to send
    assign TX_READY = (!r_r.ser_valid || SER_READY) &&
        !r_r.tx_paused && (r_r.fc_left == 2'd0);

    assign irq = r_r.irq_en[`IER_SPECIAL_BIT] &&
        (r_r.special_flag || r_r.xoff_flag);

    // ==========================================
    // next state
    always_comb begin
        r_nxt = r_r;
        r_nxt.ack = (READ | WRITE) & ~r_r.ack;
        r_nxt.fifo_valid = 1'b0;
        r_nxt.modem_prev = modem_n;
        r_nxt.modem_stat[7:4] = ~modem_n;
        if (READ && acc && ADDRESS == `OFS_MODEM_STAT) begin
            r_nxt.modem_stat[3:0] = 4'h0;
        end
        r_nxt.modem_stat[3:0] = r_nxt.modem_stat[3:0] |
            (modem_n ^ r_r.modem_prev);

        // register reads, data stands at the accept edge
        if (READ && !r_r.ack) begin
            case (ADDRESS)
                `OFS_FEATURE: r_nxt.rdata = {24'h0, r_r.feature};
                `OFS_RESUME1: r_nxt.rdata = {24'h0, r_r.resume1};
                `OFS_RESUME2: r_nxt.rdata = {24'h0, r_r.resume2};
                `OFS_PAUSE1: r_nxt.rdata = {24'h0, r_r.pause1};
                `OFS_PAUSE2: r_nxt.rdata = {24'h0, r_r.pause2};
                `OFS_IRQ_EN: r_nxt.rdata = {24'h0, r_r.irq_en};
                `OFS_IRQ_STAT: r_nxt.rdata = {26'h0, r_r.xoff_flag,
                    r_r.special_flag, 3'h0, ~irq};
                `OFS_FIFO_CTL: r_nxt.rdata = {24'h0, r_r.fifo_ctl};
                `OFS_MODEM_CTL: r_nxt.rdata = {24'h0, r_r.modem_ctl};
                `OFS_MODEM_STAT: r_nxt.rdata = {24'h0, r_r.modem_stat};
                `OFS_DIV_LOW: r_nxt.rdata = {24'h0, r_r.div_low};
                `OFS_DIV_HIGH: r_nxt.rdata = {24'h0, r_r.div_high};
                `OFS_DIV_FRAC: r_nxt.rdata = {24'h0, r_r.div_frac};
                `OFS_FLOW_STAT: r_nxt.rdata = {28'h0, r_r.rts_n,
                    r_r.tx_paused, r_r.fc_state == flow_ctrl_pkg::FC_REMOTE_PAUSED,
                    r_r.fc_left != 2'd0};
                default: r_nxt.rdata = 32'h0;
            endcase
        end

        // register writes
        if (wr) begin
            case (ADDRESS)
                // auto bits stored, no pin effect
                `OFS_FEATURE: r_nxt.feature = wd;
                `OFS_RESUME1: r_nxt.resume1 = wd;
                `OFS_RESUME2: r_nxt.resume2 = wd;
                `OFS_PAUSE1: r_nxt.pause1 = wd;
                `OFS_PAUSE2: r_nxt.pause2 = wd;
                `OFS_IRQ_EN: r_nxt.irq_en = enh ? wd :
                    ((r_r.irq_en & `IER_ENH_MASK) | (wd & ~`IER_ENH_MASK));
                `OFS_FIFO_CTL: r_nxt.fifo_ctl = enh ? wd :
                    ((r_r.fifo_ctl & `FCR_ENH_MASK) |
                    (wd & ~`FCR_ENH_MASK));
                `OFS_MODEM_CTL: r_nxt.modem_ctl = enh ? wd :
                    ((r_r.modem_ctl & `MCR_ENH_MASK) |
                    (wd & ~`MCR_ENH_MASK));
                `OFS_DIV_FRAC: if (enh) r_nxt.div_frac = wd;
                `OFS_IRQ_STAT: if (enh) begin
                    if (wd[`ISR_SPECIAL_BIT]) r_nxt.special_flag = 1'b0;
                    if (wd[`ISR_XOFF_BIT]) r_nxt.xoff_flag = 1'b0;
                end
                `OFS_DIV_LOW: r_nxt.div_low = wd;
                `OFS_DIV_HIGH: r_nxt.div_high = wd;
                default: r_nxt.ack = r_nxt.ack;
            endcase
        end

        // receive stream, set wins over clear
        if (RX_VALID) begin
            r_nxt.seq_on = seq_mode && (RX_DATA == r_r.resume1);
            r_nxt.seq_off = seq_mode && (RX_DATA == r_r.pause1);
            if (special_hit) begin
                r_nxt.special_flag = 1'b1;
            end
            if (special_hit && rsel == `SEL_PAIR2) begin
                r_nxt.xoff_flag = 1'b1;
            end
            if (off_hit) begin
                r_nxt.tx_paused = 1'b1;
            end else if (on_hit) begin
                r_nxt.tx_paused = 1'b0;
            end
            if (!drop_char) begin
                r_nxt.fifo_valid = 1'b1;
                r_nxt.fifo_data = RX_DATA;
            end
        end
        if (rsel == `SEL_NONE) begin
            r_nxt.tx_paused = 1'b0;
        end

        case (r_r.fc_state)
            flow_ctrl_pkg::FC_IDLE: begin
                if (tsel != `SEL_NONE && RX_AT_TRIGGER &&
                        r_r.fc_left == 2'd0) begin
                    r_nxt.fc_state = flow_ctrl_pkg::FC_REMOTE_PAUSED;
                    r_nxt.fc_off = 1'b1;
                    r_nxt.fc_left = (tsel == `SEL_BOTH) ? 2'd2 : 2'd1;
                end
            end
            flow_ctrl_pkg::FC_REMOTE_PAUSED: begin
                if (tsel == `SEL_NONE) begin
                    r_nxt.fc_state = flow_ctrl_pkg::FC_IDLE;
                end else if (RX_BELOW_LOWER && r_r.fc_left == 2'd0) begin
                    r_nxt.fc_state = flow_ctrl_pkg::FC_IDLE;
                    r_nxt.fc_off = 1'b0;
                    r_nxt.fc_left = (tsel == `SEL_BOTH) ? 2'd2 : 2'd1;
                end
            end
            default: r_nxt.fc_state = flow_ctrl_pkg::FC_IDLE;
        endcase

        // transmit output stage, flow chars first
        if (!r_r.ser_valid || SER_READY) begin
            r_nxt.ser_valid = 1'b0;
            if (r_r.fc_left != 2'd0) begin
                r_nxt.ser_valid = 1'b1;
                r_nxt.ser_data = fc_char;
                r_nxt.fc_left = r_r.fc_left - 2'd1;
            end else if (TX_VALID && TX_READY) begin
                r_nxt.ser_valid = 1'b1;
                r_nxt.ser_data = TX_DATA;
            end
        end

        // low below lower level, else plain bit
        if (r_r.feature[`FEAT_ARTS_BIT] && r_r.modem_ctl[`MCR_RTS_BIT]) begin
            if (RX_AT_TRIGGER) begin
                r_nxt.rts_n = 1'b1;
            end else if (RX_BELOW_LOWER) begin
                r_nxt.rts_n = 1'b0;
            end
        end else begin
            r_nxt.rts_n = ~r_r.modem_ctl[`MCR_RTS_BIT];
        end

        if (!RST_N || !POR_N) begin
            r_nxt.feature = `RST_BYTE;
            r_nxt.resume1 = `RST_BYTE;
            r_nxt.resume2 = `RST_BYTE;
            r_nxt.pause1 = `RST_BYTE;
            r_nxt.pause2 = `RST_BYTE;
            r_nxt.irq_en = `RST_BYTE;
            r_nxt.fifo_ctl = `RST_BYTE;
            r_nxt.modem_ctl = `RST_BYTE;
            r_nxt.div_frac = `RST_BYTE;
            r_nxt.modem_stat = {~modem_n, 4'h0};
            r_nxt.modem_prev = modem_n;
            r_nxt.special_flag = 1'b0;
            r_nxt.xoff_flag = 1'b0;
            r_nxt.ack = 1'b0;
            r_nxt.rdata = 32'h0;
            r_nxt.seq_on = 1'b0;
            r_nxt.seq_off = 1'b0;
            r_nxt.tx_paused = 1'b0;
            r_nxt.fc_state = flow_ctrl_pkg::FC_IDLE;
            r_nxt.fc_left = 2'd0;
            r_nxt.fc_off = 1'b0;
            r_nxt.ser_valid = 1'b0;
            r_nxt.ser_data = `RST_BYTE;
            r_nxt.fifo_valid = 1'b0;
            r_nxt.fifo_data = `RST_BYTE;
            r_nxt.rts_n = 1'b1;
        end
        // divisor low and high bytes set only at power up
        if (!POR_N) begin
            r_nxt.div_low = `RST_DIV_LOW;
            r_nxt.div_high = `RST_DIV_HIGH;
        end
    end

    always_ff @(posedge CLOCK) begin
        r_r <= r_nxt;
    end

    // ==========================================
    // outputs
    assign READDATA = r_r.rdata;
    assign WAITREQUEST = (READ | WRITE) & ~r_r.ack;
    assign FIFO_VALID = r_r.fifo_valid;
    assign FIFO_DATA = r_r.fifo_data;
    assign SER_VALID = r_r.ser_valid;
    assign SER_DATA = r_r.ser_data;

    // line and interrupt levels in reset
    assign LOGIC_LEVEL_TX_OUT = RST_N ? SER_BIT : 1'b1;
    assign LINE_TX_OUTPUTS = RST_N ? ~SER_BIT : 1'b0;
    assign INT_OE = RST_N | pin_level[4];
    assign INT_OUT = !RST_N ? 1'b1 : (pin_level[4] ? ~irq : irq);
endmodule
`default_nettype wire

// File: test/flow_ctrl_chk_sva.sv
// port checker for uart_flow_ctrl
// assumes one clock and the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module flow_ctrl_chk (
    // clock and resets
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic POR_N,
    // bus
    input wire logic READ,
    input wire logic WRITE,
    input wire logic WAITREQUEST,
    // streams
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic FIFO_VALID,
    input wire logic [7:0] FIFO_DATA,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic SER_VALID,
    input wire logic [7:0] SER_DATA,
    input wire logic SER_READY,
    // pins
    input wire logic SER_BIT,
    input wire logic LOGIC_LEVEL_TX_OUT,
    input wire logic LINE_TX_OUTPUTS,
    input wire logic INT_OUT,
    input wire logic INT_OE,
    input wire logic BUS_MODE_68
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N || !POR_N);
    // ========================================
    // bus cycle steps
    sequence s_req;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence s_ans;
        (READ || WRITE) && !WAITREQUEST;
    endsequence
    a_one_wait: assert property (s_req |=> s_ans)
        else $error("bus wait not one cycle");
    a_wait_first: assert property ($rose(READ || WRITE) |-> WAITREQUEST)
        else $error("new request accepted without a wait");
    a_tx_pins: assert property (LOGIC_LEVEL_TX_OUT == SER_BIT
        && LINE_TX_OUTPUTS == !SER_BIT)
        else $error("tx pins not tied to serial bit");
    a_fifo_cause: assert property (FIFO_VALID |-> $past(RX_VALID)
        && FIFO_DATA == $past(RX_DATA))
        else $error("fifo write without matching receive");
    a_ser_hold: assert property (SER_VALID && !SER_READY |=>
        SER_VALID && $stable(SER_DATA))
        else $error("serial char dropped while stalled");
    a_tx_accept: assert property (TX_VALID && TX_READY |=>
        SER_VALID && SER_DATA == $past(TX_DATA))
        else $error("accepted char not passed on");
    a_reset_idle: assert property ($rose(RST_N) |->
        !SER_VALID && !FIFO_VALID)
        else $error("stream active after reset");
    a_int_quiet: assert property ($rose(RST_N) |->
        !INT_OE || INT_OUT == BUS_MODE_68)
        else $error("interrupt after reset");
endmodule
bind uart_flow_ctrl flow_ctrl_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
    .POR_N(POR_N), .READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .FIFO_VALID(FIFO_VALID),
    .FIFO_DATA(FIFO_DATA), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_READY(TX_READY), .SER_VALID(SER_VALID), .SER_DATA(SER_DATA),
    .SER_READY(SER_READY), .SER_BIT(SER_BIT),
    .LOGIC_LEVEL_TX_OUT(LOGIC_LEVEL_TX_OUT),
    .LINE_TX_OUTPUTS(LINE_TX_OUTPUTS), .INT_OUT(INT_OUT), .INT_OE(INT_OE),
    .BUS_MODE_68(BUS_MODE_68));
`default_nettype wire

// File: test/remote_station.sv
// remote serial station model
// assumes the bench calls send and reads the got queue
`timescale 1ns/10ps
`default_nettype none
module remote_station (
    // clock and pace
    input wire logic CLOCK,
    input wire logic SLOW,
    // characters from the block
    input wire logic SER_VALID,
    input wire logic [7:0] SER_DATA,
    output logic SER_READY,
    output logic SER_BIT,
    // characters to the block
    output logic RX_VALID,
    output logic [7:0] RX_DATA
);
    logic [7:0] got[$];
    initial begin
        SER_READY = 1'b1;
        SER_BIT = 1'b1;
        RX_VALID = 1'b0;
        RX_DATA = 8'h00;
    end
    // ========================================
    // take chars, stall every other cycle when slow
    always @(posedge CLOCK) begin
        if (SER_VALID && SER_READY)
            got.push_back(SER_DATA);
        SER_READY <= SLOW ? !SER_READY : 1'b1;
        SER_BIT <= !SER_BIT;
    end
    task automatic send(input logic [7:0] d);
        RX_VALID <= 1'b1;
        RX_DATA <= d;
        @(posedge CLOCK);
        RX_VALID <= 1'b0;
        RX_DATA <= ~d;
        @(posedge CLOCK);
    endtask
endmodule
`default_nettype wire

// File: test/test_uart_flow_ctrl.sv
// bench for uart_flow_ctrl
// assumes remote_station and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_uart_flow_ctrl;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic POR_N = 1'b0;
    logic [3:0] ADDRESS = 4'h0;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic TX_VALID = 1'b0;
    logic [7:0] TX_DATA = 8'h00;
    logic RX_AT_TRIGGER = 1'b0;
    logic RX_BELOW_LOWER = 1'b0;
    logic SLOW = 1'b0;
    logic [3:0] BYTEENABLE = 4'hF;
    logic [3:0] MODEM_IN_N = 4'hA;
    logic BUS_MODE_68 = 1'b0;
    logic [31:0] READDATA;
    logic WAITREQUEST, RX_VALID, FIFO_VALID, TX_READY, SER_VALID, SER_READY;
    logic SER_BIT, LOGIC_LEVEL_TX_OUT, LINE_TX_OUTPUTS, INT_OUT, INT_OE;
    logic [7:0] RX_DATA, FIFO_DATA, SER_DATA, q;
    logic [7:0] fq[$];
    logic [7:0] rv[16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h50, 8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    int fails = 0;
    int n_tests = 0;
    always #5 CLOCK = ~CLOCK;
    uart_flow_ctrl dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .POR_N(POR_N),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
        .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .FIFO_VALID(FIFO_VALID),
        .FIFO_DATA(FIFO_DATA), .RX_AT_TRIGGER(RX_AT_TRIGGER),
        .RX_BELOW_LOWER(RX_BELOW_LOWER), .TX_VALID(TX_VALID),
        .TX_DATA(TX_DATA), .TX_READY(TX_READY), .SER_VALID(SER_VALID),
        .SER_DATA(SER_DATA), .SER_READY(SER_READY), .SER_BIT(SER_BIT),
        .LOGIC_LEVEL_TX_OUT(LOGIC_LEVEL_TX_OUT),
        .LINE_TX_OUTPUTS(LINE_TX_OUTPUTS), .MODEM_IN_N(MODEM_IN_N),
        .BUS_MODE_68(BUS_MODE_68), .INT_OUT(INT_OUT), .INT_OE(INT_OE));
    remote_station far_u (.CLOCK(CLOCK), .SLOW(SLOW), .SER_VALID(SER_VALID),
        .SER_DATA(SER_DATA), .SER_READY(SER_READY), .SER_BIT(SER_BIT),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA));
    always @(posedge CLOCK) if (FIFO_VALID === 1'b1) fq.push_back(FIFO_DATA);
    // ========================================
    // access and compare tasks
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic bus(input logic w, int a, logic [7:0] d);
        ADDRESS <= 4'(a);
        WRITEDATA <= {24'h0, d};
        WRITE <= w;
        READ <= !w;
        @(posedge CLOCK);
        while (WAITREQUEST !== 1'b0) @(posedge CLOCK);
        q = READDATA[7:0];
        WRITE <= 1'b0;
        READ <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic wr(input int a, logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input int a, logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", e, q);
    endtask
    task automatic rdy(input logic e);
        cyc(3);
        @(negedge CLOCK);
        chk("tx ready", {7'h0, e}, {7'h0, TX_READY});
        @(posedge CLOCK);
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 40 && far_u.got.size() < (n ? n : 9); i++)
            @(posedge CLOCK);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        cyc(5000);
        fails++;
        wrap_up;
    end
    // ========================================
    // tests
    initial begin
        int n;
        cyc(8);
        chk("reset pins", 8'h06, {4'h0, INT_OE, INT_OUT,
            LOGIC_LEVEL_TX_OUT, LINE_TX_OUTPUTS});
        RST_N <= 1'b1;
        POR_N <= 1'b1;
        for (int a = 0; a < 16; a++) rdc(a, rv[a]);
        MODEM_IN_N <= 4'hB;
        cyc(6);
        rdc(9, 8'h41);
        rdc(9, 8'h40);
        for (int a = 1; a < 5; a++) wr(a, 8'(8'h10 + a));
        for (int a = 1; a < 5; a++) rdc(a, 8'(8'h10 + a));
        $display("test reset and char registers done");
        wr(5, 8'hF0);
        rdc(5, 8'h00);
        wr(0, 8'h10);
        wr(5, 8'hF0);
        wr(12, 8'h33);
        wr(0, 8'h00);
        wr(5, 8'h00);
        wr(12, 8'h00);
        rdc(5, 8'hF0);
        rdc(12, 8'h33);
        wr(10, 8'h55);
        RST_N <= 1'b0;
        BUS_MODE_68 <= 1'b1;
        cyc(8);
        chk("reset pins", 8'h0E, {4'h0, INT_OE, INT_OUT,
            LOGIC_LEVEL_TX_OUT, LINE_TX_OUTPUTS});
        RST_N <= 1'b1;
        rdc(10, 8'h55);
        rdc(5, 8'h00);
        rdc(12, 8'h00);
        rdc(1, 8'h00);
        rdc(0, 8'h00);
        for (int a = 1; a < 5; a++) wr(a, 8'(8'h10 + a));
        BYTEENABLE <= 4'hE;
        wr(1, 8'h77);
        BYTEENABLE <= 4'hF;
        rdc(1, 8'h11);
        $display("test gate and reset done");
        wr(0, 8'h12);
        far_u.send(8'h13);
        rdy(1'b0);
        far_u.send(8'h14);
        far_u.send(8'h5A);
        far_u.send(8'h11);
        rdy(1'b1);
        TX_VALID <= 1'b1;
        TX_DATA <= 8'h77;
        @(posedge CLOCK);
        TX_VALID <= 1'b0;
        wait_got(1);
        chk("sent char", 8'h77, far_u.got[0]);
        chk("fifo count", 8'h02, 8'(fq.size()));
        chk("fifo char", 8'h14, fq[0]);
        chk("fifo char", 8'h5A, fq[1]);
        fq.delete();
        wr(0, 8'h00);
        wr(0, 8'h10);
        wr(5, 8'h20);
        wr(0, 8'h31);
        far_u.send(8'h14);
        rdy(1'b0);
        bus(1'b0, 4'h6, 8'h00);
        chk("pause flags", 8'h30, q & 8'h30);
        chk("int pin", 8'h02, {6'h0, INT_OE, INT_OUT});
        chk("fifo count", 8'h00, 8'(fq.size()));
        far_u.send(8'h12);
        rdy(1'b1);
        wr(6, 8'h30);
        wr(0, 8'h00);
        wr(0, 8'h30);
        far_u.send(8'h14);
        rdy(1'b1);
        bus(1'b0, 4'h6, 8'h00);
        chk("special flag", 8'h10, q & 8'h30);
        chk("fifo char", 8'h14, fq[0]);
        $display("test receive compare done");
        wr(0, 8'h00);
        wr(0, 8'h1B);
        far_u.send(8'h14);
        rdy(1'b0);
        far_u.send(8'h12);
        rdy(1'b1);
        wr(0, 8'h00);
        wr(0, 8'h1F);
        far_u.send(8'h13);
        rdy(1'b1);
        far_u.send(8'h14);
        rdy(1'b0);
        far_u.send(8'h11);
        far_u.send(8'h12);
        rdy(1'b1);
        $display("test both pairs done");
        wr(8, 8'h02);
        rdc(13, 8'h00);
        wr(0, 8'h50);
        RX_AT_TRIGGER <= 1'b1;
        cyc(2);
        rdc(13, 8'h08);
        RX_AT_TRIGGER <= 1'b0;
        RX_BELOW_LOWER <= 1'b1;
        cyc(2);
        rdc(13, 8'h00);
        RX_BELOW_LOWER <= 1'b0;
        $display("test auto request done");
        SLOW <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            n = (t == 3) ? 2 : (t != 0);
            wr(0, 8'h00);
            wr(0, 8'(8'h10 | (t << 2)));
            far_u.got.delete();
            RX_AT_TRIGGER <= 1'b1;
            wait_got(n);
            RX_AT_TRIGGER <= 1'b0;
            chk("pause count", 8'(n), 8'(far_u.got.size()));
            if (n > 0) chk("pause", t == 1 ? 8'h14 : 8'h13, far_u.got[0]);
            if (n > 1) chk("pause two", 8'h14, far_u.got[1]);
            far_u.got.delete();
            RX_BELOW_LOWER <= 1'b1;
            wait_got(n);
            RX_BELOW_LOWER <= 1'b0;
            chk("resume count", 8'(n), 8'(far_u.got.size()));
            if (n > 0) chk("resume", t == 1 ? 8'h12 : 8'h11, far_u.got[0]);
            if (n > 1) chk("resume two", 8'h12, far_u.got[1]);
        end
        $display("test transmit flow done");
        wrap_up;
    end
endmodule
`default_nettype wire
